// *** verilog/ptimer_defs.svh ***
// Register offsets, field positions, reset values and clock-division counts for the timer.
`ifndef PTIMER_DEFS_SVH
`define PTIMER_DEFS_SVH
// Word offsets on the register bus (byte address = 4 x index).
`define OFS_PIN_ROUTE 4'h0
`define OFS_CTRL0 4'h1
`define OFS_CTRL1 4'h2
`define OFS_CNT_LOW 4'h3
`define OFS_CNT_HIGH 4'h4
`define OFS_CMPA_LOW 4'h5
`define OFS_CMPA_HIGH 4'h6
`define OFS_CMPP_LOW 4'h7
`define OFS_CMPP_HIGH 4'h8
`define OFS_FLAGS 4'h9
// Field positions.
`define BIT_CLK_OUT_ROUTE 7
`define BIT_TIMER1_ROUTE 1
`define BIT_TIMER0_ROUTE 0
`define BIT_PAUSE 7
`define BIT_ENABLE 3
`define MASK_PIN_ROUTE 8'h83
`define MASK_CTRL0 8'hf8
`define MASK_HIGH 8'h03
`define RESET_BYTE 8'h00
// Clock divisions.
`define DIV_SYS4 4
`define DIV_H16 16
`define DIV_H64 64
`endif

// *** verilog/ptimer_pkg.sv ***
// Types shared by the timer design files.
package ptimer_pkg;
  typedef enum logic [1:0] {
    mode_compare = 2'b00,
    mode_capture = 2'b01,
    mode_pwm = 2'b10,
    mode_timer = 2'b11
  } mode_type;
  typedef enum logic [2:0] {
    clk_sys4 = 3'b000,
    clk_sys = 3'b001,
    clk_h16 = 3'b010,
    clk_h64 = 3'b011,
    clk_tbc = 3'b100,
    clk_h = 3'b101,
    clk_ext_rise = 3'b110,
    clk_ext_fall = 3'b111
  } clk_sel_type;
endpackage : ptimer_pkg

// *** verilog/tick_if.sv ***
// Carrier for the counting tick between the clock selector and the timer core.
`timescale 1ns/1ps
interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : tick_if

// *** verilog/tick_gen.sv ***
// Counter clock source selector producing a one-cycle tick.
`timescale 1ns/1ps
`include "ptimer_defs.svh"
module tick_gen
  import ptimer_pkg::*;
(
  // Clocking.
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Control.
  input wire logic [2:0] sel,
  input wire logic run,
  // Clock sources: h_en and tbc_en taken as synchronous enables, ext_in by its sampled edges.
  input wire logic h_en,
  input wire logic tbc_en,
  input wire logic ext_in,
  // Tick out.
  tick_if.src tk
);
  logic [5:0] sys_div_r;
  logic [5:0] h_div_r;
  logic ext_prev_r;
  logic tick_r;
  logic tick_nxt;

  // Free-running prescalers for the system and high clocks.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sys_div_r <= 6'h00;
      h_div_r <= 6'h00;
      ext_prev_r <= 1'b0;
    end else if (ce) begin
      sys_div_r <= (sys_div_r == 6'(`DIV_SYS4 - 1)) ? 6'h00 : sys_div_r + 6'h01;
      if (h_en) begin
        h_div_r <= h_div_r + 6'h01;
      end
      ext_prev_r <= ext_in;
    end
  end

  always_comb begin
    tick_nxt = 1'b0;
    unique case (clk_sel_type'(sel))
      clk_sys4: tick_nxt = (sys_div_r == 6'h00);
      clk_sys: tick_nxt = 1'b1;
      clk_h16: tick_nxt = h_en && (h_div_r[3:0] == 4'(`DIV_H16 - 1));
      clk_h64: tick_nxt = h_en && (h_div_r == 6'(`DIV_H64 - 1));
      clk_tbc: tick_nxt = tbc_en;
      clk_h: tick_nxt = h_en;
      clk_ext_rise: tick_nxt = ext_in && !ext_prev_r;
      clk_ext_fall: tick_nxt = !ext_in && ext_prev_r;
    endcase
  end

  // Registered tick; gated by run so a stopped timer sees no edges.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= tick_nxt && run;
    end
  end

  assign tk.tick = tick_r;
endmodule : tick_gen

// *** verilog/periodic_timer.sv ***
// Ten-bit periodic timer with Avalon-MM register access.
`timescale 1ns/1ps
`include "ptimer_defs.svh"
module periodic_timer
  import ptimer_pkg::*;
(
  // Clocking.
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Clock sources.
  input wire logic h_en,
  input wire logic tbc_en,
  input wire logic ext_count_input,
  // Pin routing and output.
  output logic clk_out_route,
  output logic timer1_pin_route,
  output logic timer0_pin_route,
  output logic timer_output_pin,
  // Match flags.
  output logic match_a_flag,
  output logic match_p_flag
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] route_r;
  logic count_pause;
  logic [2:0] count_clk_select;
  logic timer_enable;
  logic [7:0] ctrl1_r;
  logic [7:0] hold_r;
  logic [9:0] count_r;
  logic [9:0] compare_a_value;
  logic [9:0] compare_p_value;
  logic en_prev_r;
  logic out_r;
  logic pulse_done_r;
  logic flag_a_r;
  logic flag_p_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic access;
  logic wr_now;
  logic en_rise;
  logic match_a;
  logic match_p;
  logic overflow;
  logic clr_hit;
  logic tick;
  mode_type operating_mode_sel;
  logic [1:0] output_function_sel;
  logic output_initial_level;
  logic output_invert;
  logic count_clear_select;
  tick_if tk ();

  // Control fields from the control registers.
  assign operating_mode_sel = mode_type'(ctrl1_r[7:6]);
  assign output_function_sel = ctrl1_r[5:4];
  assign output_initial_level = ctrl1_r[3];
  assign output_invert = ctrl1_r[2];
  assign count_clear_select = ctrl1_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: every access takes exactly one wait cycle, so the
  // registered read data is ready on the edge where waitrequest drops.
  // Waitrequest comes from its own flop, reset high, so the bus stalls
  // until the block is out of reset and no gate sits on the output.
  assign access = (read || write) && !ack_r;
  assign wr_now = write && ack_r;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      waitrequest <= 1'b1;
    end else if (ce) begin
      ack_r <= access;
      waitrequest <= !access;
    end
  end

  // Pack a value into the low bits of a bus word.
  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction : word8

  // Read mux with zero reserved bits.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_r <= 32'h00000000;
    end else if (ce && access && read) begin
      unique case (address)
        `OFS_PIN_ROUTE: rdata_r <= word8(route_r & `MASK_PIN_ROUTE);
        `OFS_CTRL0: rdata_r <= word8({count_pause, count_clk_select, timer_enable, 3'b000});
        `OFS_CTRL1: rdata_r <= word8(ctrl1_r);
        // Low bytes read the holding buffer.
        `OFS_CNT_LOW, `OFS_CMPA_LOW, `OFS_CMPP_LOW: rdata_r <= word8(hold_r);
        `OFS_CNT_HIGH: rdata_r <= word8({6'h00, count_r[9:8]});
        `OFS_CMPA_HIGH: rdata_r <= word8({6'h00, compare_a_value[9:8]});
        `OFS_CMPP_HIGH: rdata_r <= word8({6'h00, compare_p_value[9:8]});
        `OFS_FLAGS: rdata_r <= word8({6'h00, flag_p_r, flag_a_r});
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  assign readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing register.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      route_r <= `RESET_BYTE;
    end else if (ce && wr_now && address == `OFS_PIN_ROUTE) begin
      route_r <= writedata[7:0] & `MASK_PIN_ROUTE;
    end
  end

  // Routing outputs are registered copies; one cycle of lag is harmless
  // because pin sharing is set up once, long before the pins are used.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      clk_out_route <= 1'b0;
      timer1_pin_route <= 1'b0;
      timer0_pin_route <= 1'b0;
    end else if (ce) begin
      clk_out_route <= route_r[`BIT_CLK_OUT_ROUTE];
      timer1_pin_route <= route_r[`BIT_TIMER1_ROUTE];
      timer0_pin_route <= route_r[`BIT_TIMER0_ROUTE];
    end
  end

  // Control register writes land on the acknowledge edge.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      count_pause <= 1'b0;
      count_clk_select <= 3'b000;
      timer_enable <= 1'b0;
      ctrl1_r <= `RESET_BYTE;
    end else if (ce && wr_now) begin
      if (address == `OFS_CTRL0) begin
        count_pause <= writedata[`BIT_PAUSE];
        count_clk_select <= writedata[6:4];
        timer_enable <= writedata[`BIT_ENABLE];
      end
      if (address == `OFS_CTRL1) begin
        ctrl1_r <= writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding buffer, shared by all three pairs; a mixed sequence across
  // pairs corrupts coherence, which software must avoid. A high read
  // snaps the low byte on the same edge that samples the high byte, so
  // a carry between the two halves can never tear the value.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hold_r <= `RESET_BYTE;
    end else if (ce) begin
      if (wr_now && (address == `OFS_CMPA_LOW || address == `OFS_CMPP_LOW)) begin
        hold_r <= writedata[7:0];
      end else if (access && read) begin
        unique case (address)
          `OFS_CNT_HIGH: hold_r <= count_r[7:0];
          `OFS_CMPA_HIGH: hold_r <= compare_a_value[7:0];
          `OFS_CMPP_HIGH: hold_r <= compare_p_value[7:0];
          default: hold_r <= hold_r;
        endcase
      end
    end
  end

  // High write copies buffer to low.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      compare_a_value <= 10'h000;
      compare_p_value <= 10'h000;
    end else if (ce && wr_now) begin
      if (address == `OFS_CMPA_HIGH) begin
        compare_a_value <= {writedata[1:0], hold_r};
      end
      if (address == `OFS_CMPP_HIGH) begin
        compare_p_value <= {writedata[1:0], hold_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection.
  tick_gen tick_gen_inst (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .sel(count_clk_select),
    .run(timer_enable && !count_pause),
    .h_en(h_en),
    .tbc_en(tbc_en),
    .ext_in(ext_count_input),
    .tk(tk)
  );

  assign tick = tk.tick;

  // Enable edge detection; the flop resets low like the enable bit, so
  // no false rise follows reset.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      en_prev_r <= 1'b0;
    end else if (ce) begin
      en_prev_r <= timer_enable;
    end
  end

  assign en_rise = timer_enable && !en_prev_r;

  // Full ten-bit comparators.
  // A zero period value disables the P match so overflow can take over.
  assign match_a = tick && (count_r == compare_a_value);
  assign match_p = tick && (compare_p_value != 10'h000) && (count_r == compare_p_value);
  assign overflow = tick && (count_r == 10'h3ff);

  assign clr_hit = count_clear_select ? match_a : (match_p || (compare_p_value == 10'h000
                   && overflow));

  // Counter; only enable rise clears it from software.
  // The tick arrives one cycle after its source event, so the first
  // count after an enable rise lands two cycles later.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      count_r <= 10'h000;
    end else if (ce) begin
      if (en_rise) begin
        count_r <= 10'h000;
      end else if (tick) begin
        // Pause or disable gate the tick, holding the value.
        count_r <= clr_hit ? 10'h000 : count_r + 10'h001;
      end
    end
  end

  // Sticky flags; a new match wins over a clear by writing one.
  // Write-one-to-clear lets software drop one flag without touching
  // the other.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else if (ce) begin
      if (match_a) begin
        flag_a_r <= 1'b1;
      end else if (wr_now && address == `OFS_FLAGS && writedata[0]) begin
        flag_a_r <= 1'b0;
      end
      if (match_p && !count_clear_select) begin
        flag_p_r <= 1'b1;
      end else if (wr_now && address == `OFS_FLAGS && writedata[1]) begin
        flag_p_r <= 1'b0;
      end
    end
  end

  assign match_a_flag = flag_a_r;
  assign match_p_flag = flag_p_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output level before polarity; mode decides the behaviour.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      out_r <= 1'b0;
      pulse_done_r <= 1'b0;
    end else if (ce) begin
      unique case (operating_mode_sel)
        mode_compare: begin
          if (en_rise) begin
            out_r <= output_initial_level;
          end else if (match_a) begin
            unique case (output_function_sel)
              2'b00: out_r <= out_r;
              2'b01: out_r <= 1'b0;
              2'b10: out_r <= 1'b1;
              2'b11: out_r <= !out_r;
            endcase
          end
        end
        mode_pwm: begin
          // Active level follows output control bit.
          if (en_rise) begin
            pulse_done_r <= 1'b0;
          end
          unique case (output_function_sel)
            2'b00: out_r <= !output_initial_level;
            2'b01: out_r <= output_initial_level;
            2'b10: begin
              if (match_p || (tick && count_r == 10'h000)) begin
                out_r <= output_initial_level;
              end else if (match_a) begin
                out_r <= !output_initial_level;
              end
            end
            2'b11: begin
              if (en_rise) begin
                out_r <= output_initial_level;
              end else if (match_a || !timer_enable) begin
                out_r <= !output_initial_level;
                pulse_done_r <= 1'b1;
              end else if (!pulse_done_r && timer_enable) begin
                out_r <= output_initial_level;
              end
            end
          endcase
        end
        // Timer and capture modes leave the pin function to software.
        mode_capture, mode_timer: out_r <= out_r;
      endcase
    end
  end

  // Polarity inversion, not in timer mode.
  // Applied last so compare and pulse modes see it alike.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      timer_output_pin <= 1'b0;
    end else if (ce) begin
      timer_output_pin <= (output_invert && operating_mode_sel != mode_timer) ? !out_r : out_r;
    end
  end
endmodule : periodic_timer

// *** bench/periodic_timer_asserts.sv ***
// Concurrent checks on the timer's bus answer, route outputs and match flags.
`timescale 1ns/1ps
module periodic_timer_asserts (
  // Clocking.
  input wire logic mclk,
  input wire logic rstn,
  // Register bus.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Observed outputs.
  input wire logic clk_out_route,
  input wire logic timer1_pin_route,
  input wire logic timer0_pin_route,
  input wire logic match_a_flag,
  input wire logic match_p_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////////////
  // An access completes in the one cycle that waitrequest is low.
  logic acc;
  logic rd_acc;
  logic clr_a;
  logic clr_p;
  assign acc = (read | write) & ~waitrequest;
  assign rd_acc = acc & read;
  assign clr_a = acc & write & (address == 4'h9) & writedata[0];
  assign clr_p = acc & write & (address == 4'h9) & writedata[1];
  ////////////////////////////////////////////////////////////////////////////////////////
  property p_wait_one;
    !waitrequest |=> waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("Wait low too long.");
  property p_answer;
    (read | write) && waitrequest |-> ##[1:2] !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("Request not answered.");
  property p_route_hi;
    acc && write && address == 4'h0 |-> ##2 clk_out_route == $past(writedata[7], 2);
  endproperty
  a_route_hi: assert property (p_route_hi) else $error("Clock route wrong.");
  property p_route_lo;
    acc && write && address == 4'h0 |-> ##2
      timer1_pin_route == $past(writedata[1], 2) && timer0_pin_route == $past(writedata[0], 2);
  endproperty
  a_route_lo: assert property (p_route_lo) else $error("Timer route wrong.");
  property p_pad_route;
    rd_acc && address == 4'h0 |-> readdata[6:2] == 5'h0;
  endproperty
  a_pad_route: assert property (p_pad_route) else $error("Route pad set.");
  property p_pad_ctrl;
    rd_acc && address == 4'h1 |-> readdata[2:0] == 3'h0;
  endproperty
  a_pad_ctrl: assert property (p_pad_ctrl) else $error("Control pad set.");
  property p_pad_high;
    rd_acc && (address == 4'h4 || address == 4'h6 || address == 4'h8) |-> readdata[7:2] == 6'h0;
  endproperty
  a_pad_high: assert property (p_pad_high) else $error("High pad set.");
  property p_hold_a;
    $fell(match_a_flag) |-> $past(clr_a);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("A flag lost.");
  property p_hold_p;
    $fell(match_p_flag) |-> $past(clr_p);
  endproperty
  a_hold_p: assert property (p_hold_p) else $error("P flag lost.");
endmodule : periodic_timer_asserts

bind periodic_timer periodic_timer_asserts periodic_timer_asserts_inst (.mclk, .rstn,
  .address, .read, .write, .writedata, .readdata, .waitrequest, .clk_out_route,
  .timer1_pin_route, .timer0_pin_route, .match_a_flag, .match_p_flag);

// *** bench/tb_top.sv ***
// Self-checking testbench for the periodic timer.
`timescale 1ns/1ps
module tb_top;
  logic mclk, rstn, ce, read, write, waitrequest, h_en, tbc_en, ext_count_input;
  logic clk_out_route, timer1_pin_route, timer0_pin_route, timer_output_pin;
  logic match_a_flag, match_p_flag;
  logic [3:0] address;
  logic [31:0] writedata, readdata;
  logic [7:0] q;
  logic [9:0] v, w;
  int failures, cmp_count, cyc;

  // Every input is exercised, the clock enable included.
  periodic_timer periodic_timer_inst (.mclk, .rstn, .ce, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .h_en, .tbc_en, .ext_count_input, .clk_out_route,
    .timer1_pin_route, .timer0_pin_route, .timer_output_pin, .match_a_flag, .match_p_flag);

  // Clock at 200 MHz.
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  // Hang guard; the whole run needs well under this many cycles.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] time %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request stays put until waitrequest is sampled low, however long that takes.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= {24'h0, d};
    do @(posedge mclk); while (waitrequest !== 1'h0);
    q = readdata[7:0];
    write <= 1'h0;
    read <= 1'h0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h0);
    chk(q, e);
  endtask : rdc

  // High byte first, so the buffered low byte belongs to the same value.
  task automatic cnt(output logic [9:0] c);
    bus(1'h0, 4'h4, 8'h0);
    c[9:8] = q[1:0];
    bus(1'h0, 4'h3, 8'h0);
    c[7:0] = q;
  endtask : cnt

  // One event of the chosen source, then three quiet cycles.
  task automatic ev(input logic [2:0] s);
    h_en <= (s == 3'h5);
    tbc_en <= (s == 3'h4);
    ext_count_input <= s[1];
    @(posedge mclk);
    h_en <= 1'h0;
    tbc_en <= 1'h0;
    ext_count_input <= 1'h0;
    repeat (3) @(posedge mclk);
  endtask : ev
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc(4'h0, 8'h00); // Route starts clear.
    wr(4'h0, 8'hff);
    rdc(4'h0, 8'h83); // Pads read zero.
    chk({clk_out_route, timer1_pin_route, timer0_pin_route}, 3'h7); // Pins routed.
    wr(4'h0, 8'h00);
    repeat (3) @(posedge mclk);
    chk({clk_out_route, timer1_pin_route, timer0_pin_route}, 3'h0); // Pins released.
    rdc(4'h1, 8'h00); // Control starts clear.
    wr(4'h1, 8'hff);
    rdc(4'h1, 8'hf8); // Pads read zero.
    wr(4'h1, 8'h00);
  endtask : t_regs

  task automatic t_pairs();
    for (logic [3:0] b = 4'h5; b < 4'h9; b += 4'h2) begin
      wr(b, 8'h5a);
      wr(b + 4'h1, 8'h02);
      rdc(b + 4'h1, 8'h02); // High byte written.
      rdc(b, 8'h5a); // Low byte copied.
      wr(b, 8'h11);
      rdc(b + 4'h1, 8'h02); // High read latches low.
      rdc(b, 8'h5a); // Low byte kept.
    end
  endtask : t_pairs

  task automatic t_count();
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h18);
    cnt(v);
    cnt(w);
    chk(w > v, 1'h1); // Counter advances.
    ce <= 1'h0;
    repeat (40) @(posedge mclk);
    ce <= 1'h1;
    cnt(v);
    chk(v < w + 10'h14, 1'h1); // Frozen while clock enable low.
    wr(4'h1, 8'h98);
    cnt(v);
    repeat (20) @(posedge mclk);
    cnt(w);
    chk(w, v); // Paused count held.
    wr(4'h1, 8'h18);
    repeat (4) @(posedge mclk);
    cnt(w);
    chk(w > v && w < v + 10'h28, 1'h1); // Resumes from held value.
    wr(4'h1, 8'h10);
    cnt(v);
    repeat (20) @(posedge mclk);
    cnt(w);
    chk(w, v); // Stopped count kept.
    wr(4'h1, 8'h18);
    cnt(w);
    chk(w < 10'hc && v > 10'h10, 1'h1); // Enable clears count.
  endtask : t_count

  task automatic t_src();
    for (int s = 4; s < 8; s++) begin
      wr(4'h1, {1'h0, 3'(s), 4'h0});
      wr(4'h1, {1'h0, 3'(s), 4'h8});
      repeat (6) ev(3'(s));
      cnt(v);
      chk(v, 10'h6); // Source events counted.
    end
  endtask : t_src

  // Divided sources, counted over 128 cycles with the high enable held.
  task automatic t_div();
    logic [2:0] s;
    logic [9:0] e;
    h_en <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      s = (i == 0) ? 3'h0 : 3'(i + 1);
      e = (i == 0) ? 10'h20 : (i == 1) ? 10'h8 : 10'h2;
      wr(4'h1, {1'h0, s, 4'h0});
      wr(4'h1, {1'h0, s, 4'h8});
      repeat (128) @(posedge mclk);
      cnt(v);
      chk(v + 10'h1 >= e && v <= e + 10'h2, 1'h1); // Divided rate.
    end
    h_en <= 1'h0;
  endtask : t_div

  // Compare output with A clearing: every action, both start levels, both polarities.
  task automatic t_cmp();
    logic [1:0] io;
    logic oc, pol, e;
    wr(4'h7, 8'h80);
    wr(4'h8, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h01);
    for (int k = 0; k < 10; k++) begin
      io = 2'(k);
      oc = k[2];
      pol = k[3];
      wr(4'h1, 8'h10);
      wr(4'h9, 8'h03);
      wr(4'h2, {2'h0, io, oc, pol, 2'h1});
      wr(4'h1, 8'h18);
      repeat (3) @(posedge mclk);
      chk(timer_output_pin, oc ^ pol); // Start level.
      while (match_a_flag !== 1'h1) @(posedge mclk);
      repeat (3) @(posedge mclk);
      e = (io == 2'h0) ? oc : (io == 2'h3) ? ~oc : io[1];
      chk(timer_output_pin, e ^ pol); // Match action applied.
      chk(match_p_flag, 1'h0); // No P flag.
    end
  endtask : t_cmp

  task automatic t_pclr();
    wr(4'h1, 8'h10);
    wr(4'h9, 8'h03);
    wr(4'h7, 8'h20);
    wr(4'h8, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h18);
    while (match_p_flag !== 1'h1) @(posedge mclk);
    wr(4'h1, 8'h98);
    cnt(v);
    chk(v < 10'h20 && match_a_flag === 1'h0, 1'h1); // Cleared on P match.
    wr(4'h9, 8'h02);
    @(posedge mclk);
    chk(match_p_flag, 1'h0); // Flag cleared.
  endtask : t_pclr

  // Pulse modes with A at 0x010 inside a P period of 0x020.
  task automatic t_pwm();
    wr(4'h5, 8'h10);
    wr(4'h6, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(4'h1, 8'h10);
      wr(4'h9, 8'h03);
      wr(4'h2, {2'h2, 2'(k), 4'h8});
      wr(4'h1, 8'h18);
      repeat (3) @(posedge mclk);
      chk(timer_output_pin, k != 0); // Forced or starting level.
      if (k > 1) begin
        while (match_a_flag !== 1'h1) @(posedge mclk);
        repeat (3) @(posedge mclk);
        chk(timer_output_pin, 1'h0); // Inactive after A match.
      end
      if (k == 2) begin
        while (match_p_flag !== 1'h1) @(posedge mclk);
        repeat (3) @(posedge mclk);
        chk(timer_output_pin, 1'h1); // Active from period start.
      end
    end
  endtask : t_pwm
  ////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rstn = 1'h0;
    ce = 1'h1;
    read = 1'h0;
    write = 1'h0;
    address = 4'h0;
    writedata = 32'h0;
    h_en = 1'h0;
    tbc_en = 1'h0;
    ext_count_input = 1'h0;
    repeat (20) @(posedge mclk);
    rstn <= 1'h1;
    t_regs();
    t_pairs();
    t_count();
    t_src();
    t_div();
    t_cmp();
    t_pclr();
    t_pwm();
    complete_run();
  end
endmodule : tb_top
